// ### pkg/thermal_pkg.sv
package thermal_pkg;

  // Temperature word width and duty field layout
  localparam int TEMP_W = 8;
  localparam int DUTY_POS = 1;
  localparam int DUTY_W = 3;
  localparam int OD_EN_POS = 4;
  localparam int CTRL_W = 5;

  // Modulation slice length in clock cycles, eight slices per period
  localparam int SLICE_CYCLES = 16;
  localparam int SLICES = 8;
  localparam logic [DUTY_W-1:0] AUTO_DUTY = 3'h4;

  // Hysteresis time and derived cycle count at 100 MHz
  localparam int HYST_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int HYST_CYCLES = (HYST_NS + CLK_NS - 1) / CLK_NS;

  // Reset values
  localparam logic [TEMP_W-1:0] MARGIN_RST = 8'h00;

  // Software control bits
  typedef struct packed {
    logic auto_en;
    logic od_en;
    logic [DUTY_W-1:0] od_duty;
    logic hot_irq_en;
    logic [TEMP_W-1:0] thr1;
    logic [TEMP_W-1:0] thr2;
    logic thr1_irq_en;
    logic thr2_irq_en;
  } ctrl_t;

  // Sensor inputs
  typedef struct packed {
    logic [TEMP_W-1:0] die_temp;
    logic [TEMP_W-1:0] tj_max;
    logic [TEMP_W-1:0] trip_temp;
    logic hot_in_n;
    logic low_power;
  } sense_t;

  // Sensor readback
  typedef struct packed {
    logic [TEMP_W-1:0] margin;
    logic valid;
    logic out_of_spec;
  } sensor_rd_t;

  typedef enum logic [1:0] {
    TH_IDLE,
    TH_ACTIVE,
    TH_HYST
  } auto_state_t;

endpackage

// ### design/thermal_throttle_control.sv
`timescale 1ns/1ps
// Functional notes
// - Throttle engages at the maximum die temperature; trip point is fixed.
// - Snooping continues; interrupt requests latch, serviced only while clocks run.
// - Automatic and on-demand modes both trigger; automatic wins when both active.
// - Automatic mode enabled by software; engages at maximum die temperature or on an externally driven hot indicator.
// - Automatic mode uses fixed fifty percent duty cycle.
// - Automatic throttle releases after cooling, with hysteresis timer.
// - On-demand enable bit 4 engages throttling at once regardless of temperature.
// - On-demand duty from bits 3:1, 12.5 to 87.5 percent on-time.
// - Both requesting at once: automatic fixed duty overrides on-demand.
// - Active-low hot indicator asserts when die is at or above trip point.
// - Optional interrupt on hot indicator assertion and de-assertion.
// - No new hot assertion while in a low-power state.
// - Hot held through low-power state until exit and cooled below trip.
// - Catastrophic trip asserts and shuts down at about 125 C.
// - Catastrophic trip independent of activity, makes no bus transactions.
// - Die sensor readable only via register, valid only in normal running state.
// - Sensor reports margin to maximum junction temperature, never above it.
// - Out-of-spec flag sets on over-temperature condition.
// - Sensor zero-margin point equals automatic trip point.
// - Two programmable thresholds raise interrupts on crossing.
// - Externally driven hot indicator engages throttling if enabled.
// - External throttling lasts until the pin is released.
module thermal_throttle_control
  import thermal_pkg::*;
#(
  parameter int SLICE_LEN = SLICE_CYCLES,
  parameter int HYST_LEN = HYST_CYCLES
)(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire ctrl_t ctrl_i,
  input wire sense_t sense_i,
  input wire logic catastrophic_i,
  input wire logic irq_req_i,
  input wire logic snoop_req_i,
  output logic core_clk_en_o,
  output logic throttle_active_o,
  output logic hot_indicator_n_o,
  output logic hot_indicator_oe_o,
  output logic catastrophic_trip_n_o,
  output logic shutdown_o,
  output logic irq_service_o,
  output logic snoop_ack_o,
  output logic hot_irq_o,
  output logic thr_irq_o,
  output sensor_rd_t sensor_o
);

  // Elaboration check: both counters are sixteen bits wide
  // A zero length would wrap the slice end compare to 65535, a 65536-cycle slice
  if (SLICE_LEN < 1 || SLICE_LEN > 65535 || HYST_LEN < 1 || HYST_LEN > 65535)
  begin : g_bad_counts
    $error("thermal_throttle_control: counts out of range");
  end

  // Whole state of the block, registered as one word
  // Active-low pins have flops of their own so no output passes a gate
  typedef struct packed {
    auto_state_t auto_st;
    logic [15:0] hyst_cnt;
    logic [15:0] slice_cnt;
    logic [2:0] slice_idx;
    logic [DUTY_W-1:0] duty_lat;
    logic od_run;
    logic clk_en;
    logic thr_act;
    logic hot_drv;
    logic hot_n;
    logic trip;
    logic trip_n;
    logic irq_pend;
    logic irq_svc;
    logic snoop_ack;
    logic hot_irq;
    logic thr_irq;
    logic above1;
    logic above2;
    sensor_rd_t sensor;
  } state_t;

  // Present state and its next value
  state_t st_reg;
  state_t st_next;

  // Helper terms shared by the next-state logic
  logic at_max;
  logic above_max;
  logic ext_hot;
  logic auto_req;
  logic slice_end;
  logic period_end;
  logic auto_on;
  logic od_on;
  logic [DUTY_W-1:0] od_slices;
  logic [TEMP_W-1:0] margin;
  logic [TEMP_W:0] temp_ext;
  logic [TEMP_W:0] max_ext;

  // Sensor conditions; the temperature ones are compared against the fixed maximum, the hot pin is not
  // The maximum is a sensor input, never a software field
  always_comb
  begin
    // Extend by one bit so the compares never wrap
    temp_ext = {1'b0, sense_i.die_temp};
    max_ext = {1'b0, sense_i.tj_max};
    at_max = temp_ext >= max_ext;
    // Strictly above the maximum counts as out of spec
    above_max = temp_ext > max_ext;
    // Pin seen low while we are not driving it: the platform pulls it
    ext_hot = !sense_i.hot_in_n && !st_reg.hot_drv;
    if (at_max)
      margin = MARGIN_RST;
    else
      margin = TEMP_W'(sense_i.tj_max - sense_i.die_temp);
    // Slice and period boundaries of the modulation counter
    slice_end = st_reg.slice_cnt == 16'(SLICE_LEN - 1);
    period_end = slice_end && (st_reg.slice_idx == 3'h7);
  end

  // Next state of the whole block
  // Pulses default low so each one stands for a single cycle
  always_comb
  begin
    st_next = st_reg;
    st_next.hot_irq = 1'b0;
    st_next.thr_irq = 1'b0;
    st_next.irq_svc = 1'b0;
    auto_req = 1'b0;
    auto_on = 1'b0;
    od_on = 1'b0;
    od_slices = st_reg.duty_lat;

    // automatic engage and hysteresis release
    // Disabling automatic mode drops it at once from any state
    case (st_reg.auto_st)
      TH_IDLE:
      begin
        if (ctrl_i.auto_en && at_max)
          st_next.auto_st = TH_ACTIVE;
      end
      TH_ACTIVE:
      begin
        // Cooling below the maximum starts the hysteresis timer
        if (!ctrl_i.auto_en)
          st_next.auto_st = TH_IDLE;
        else if (!at_max)
        begin
          st_next.auto_st = TH_HYST;
          st_next.hyst_cnt = '0;
        end
      end
      TH_HYST:
      begin
        // timer must expire cool
        // Reheating during the timer returns to active, no toggling
        if (!ctrl_i.auto_en)
          st_next.auto_st = TH_IDLE;
        else if (at_max)
          st_next.auto_st = TH_ACTIVE;
        else if (st_reg.hyst_cnt == 16'(HYST_LEN - 1))
          st_next.auto_st = TH_IDLE;
        else
          st_next.hyst_cnt = st_reg.hyst_cnt + 16'h0001;
      end
      default:
        // Unused code recovers to idle
        st_next.auto_st = TH_IDLE;
    endcase

    // held until pin released
    // No hysteresis here: the platform decides how long it holds the pin
    auto_req = (st_reg.auto_st != TH_IDLE) || (ctrl_i.auto_en && ext_hot);

    // Free-running modulation counter: slices of SLICE_LEN cycles
    // Automatic and on-demand modulation share the same period
    if (slice_end)
    begin
      st_next.slice_cnt = '0;
      st_next.slice_idx = st_reg.slice_idx + 3'h1;
    end
    else
      st_next.slice_cnt = st_reg.slice_cnt + 16'h0001;

    // on-demand starts at once
    // The period restarts so the first on-time is a whole one
    // This comes after the counter so the restart wins
    if (ctrl_i.od_en && !st_reg.od_run)
    begin
      st_next.od_run = 1'b1;
      st_next.slice_cnt = '0;
      st_next.slice_idx = '0;
    end
    else if (!ctrl_i.od_en && st_reg.od_run && period_end)
      st_next.od_run = 1'b0;

    // duty latched each period
    // A new field value waits for the boundary, so no runt slice appears
    if (period_end || !st_reg.od_run)
      st_next.duty_lat = ctrl_i.od_duty;
    // Codes one to seven give that many slices of eight on
    // Code zero is held at the lowest step, one slice on
    if (st_reg.duty_lat == '0)
      od_slices = DUTY_W'(1);
    else
      od_slices = st_reg.duty_lat;

    // fifty percent
    // Automatic mode runs the first half of every period
    auto_on = st_next.slice_idx < AUTO_DUTY;
    // On-demand runs the first od_slices slices of every period
    od_on = st_next.slice_idx < od_slices;

    st_next.thr_act = auto_req || st_reg.od_run;
    // Trip stops the clocks for good, above either mode
    if (st_reg.trip)
      st_next.clk_en = 1'b0;
    else if (auto_req)
      st_next.clk_en = auto_on;
    else if (st_reg.od_run)
      st_next.clk_en = od_on;
    else
      st_next.clk_en = 1'b1;

    // latch interrupts, serve while clocks run
    // A request in the serving cycle stays pending, none is lost
    if (irq_req_i)
      st_next.irq_pend = 1'b1;
    if (st_reg.irq_pend && st_reg.clk_en)
    begin
      st_next.irq_svc = 1'b1;
      st_next.irq_pend = irq_req_i;
    end
    // Snoops are answered whatever the clock gate does
    st_next.snoop_ack = snoop_req_i;

    // no new assertion in low power
    if (sense_i.low_power)
      st_next.hot_drv = st_reg.hot_drv;
    else
      st_next.hot_drv = at_max;
    // Pin level is the inverse of the drive, from its own flop
    st_next.hot_n = !st_next.hot_drv;
    if (ctrl_i.hot_irq_en && (st_next.hot_drv != st_reg.hot_drv))
      st_next.hot_irq = 1'b1;

    // independent of activity
    // Only reset clears it; no bus request is raised
    if (catastrophic_i)
    begin
      st_next.trip = 1'b1;
      st_next.trip_n = 1'b0;
    end

    st_next.sensor.valid = !sense_i.low_power;
    // Reading frozen while in a low-power state
    if (!sense_i.low_power)
      st_next.sensor.margin = margin;
    if (catastrophic_i || above_max)
      st_next.sensor.out_of_spec = 1'b1;

    // threshold crossings
    // Either direction of a crossing raises the pulse
    st_next.above1 = sense_i.die_temp >= ctrl_i.thr1;
    st_next.above2 = sense_i.die_temp >= ctrl_i.thr2;
    if ((ctrl_i.thr1_irq_en && (st_next.above1 != st_reg.above1))
        || (ctrl_i.thr2_irq_en && (st_next.above2 != st_reg.above2)))
      st_next.thr_irq = 1'b1;
  end

  // State register
  // Reset leaves clocks running and both active-low pins released
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= '0;
      st_reg.auto_st <= TH_IDLE;
      st_reg.clk_en <= 1'b1;
      st_reg.hot_n <= 1'b1;
      st_reg.trip_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state flops
  assign core_clk_en_o = st_reg.clk_en;
  assign throttle_active_o = st_reg.thr_act;
  assign hot_indicator_n_o = st_reg.hot_n;
  assign hot_indicator_oe_o = st_reg.hot_drv;
  assign catastrophic_trip_n_o = st_reg.trip_n;
  assign shutdown_o = st_reg.trip;
  assign irq_service_o = st_reg.irq_svc;
  assign snoop_ack_o = st_reg.snoop_ack;
  assign hot_irq_o = st_reg.hot_irq;
  assign thr_irq_o = st_reg.thr_irq;
  assign sensor_o = st_reg.sensor;

endmodule

// ### test/thermal_chk_sva.sv
`timescale 1ns/1ps
module thermal_chk
  import thermal_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire sense_t sense_i,
  input wire logic catastrophic_i,
  input wire logic snoop_req_i,
  input wire logic core_clk_en_o,
  input wire logic throttle_active_o,
  input wire logic hot_indicator_n_o,
  input wire logic hot_indicator_oe_o,
  input wire logic catastrophic_trip_n_o,
  input wire logic shutdown_o,
  input wire logic snoop_ack_o,
  input wire sensor_rd_t sensor_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Port relations checked every edge
  a_snoop_pass: assert property (snoop_req_i |=> snoop_ack_o) else $error("snoop lost");
  a_trip_follows: assert property (catastrophic_i |=> !catastrophic_trip_n_o && shutdown_o)
    else $error("trip late");
  a_trip_sticky: assert property (!catastrophic_trip_n_o |=> (!catastrophic_trip_n_o)[*3])
    else $error("trip released");
  a_margin_zero: assert property (!sense_i.low_power && sense_i.die_temp >= sense_i.tj_max
    |=> sensor_o.margin == 8'h00) else $error("margin above max");
  a_valid_run: assert property (sense_i.low_power |=> !sensor_o.valid) else $error("valid");
  a_oos_sticky: assert property (sensor_o.out_of_spec |=> sensor_o.out_of_spec)
    else $error("flag cleared");
  a_hot_low: assert property (hot_indicator_oe_o |-> !hot_indicator_n_o) else $error("hot");
  a_no_new_hot: assert property ($rose(hot_indicator_oe_o) |-> !$past(sense_i.low_power))
    else $error("hot in low power");
  a_idle_clocks: assert property (!throttle_active_o && !shutdown_o |-> core_clk_en_o)
    else $error("gated");
  c_trip: cover property (catastrophic_i);
  c_gated: cover property (throttle_active_o && !core_clk_en_o);
  c_hot: cover property (hot_indicator_oe_o);
endmodule
bind thermal_throttle_control thermal_chk thermal_chk_i (.sys_clk_i, .rst_b_i, .sense_i,
  .catastrophic_i, .snoop_req_i, .core_clk_en_o, .throttle_active_o, .hot_indicator_n_o,
  .hot_indicator_oe_o, .catastrophic_trip_n_o, .shutdown_o, .snoop_ack_o, .sensor_o);

// ### test/hot_platform.sv
`timescale 1ns/1ps
module hot_platform (
  input wire logic drive_i,
  input wire logic dev_n_i,
  input wire logic dev_oe_i,
  output logic pin_n_o
);
  // platform pull
  // Pulled-up wire: either party pulls it low, release lets it float high
  assign pin_n_o = !((dev_oe_i && !dev_n_i) || drive_i);
endmodule

// ### test/tb_thermal_throttle_control.sv
`timescale 1ns/1ps
module tb_thermal_throttle_control;
  import thermal_pkg::*;
  logic clk = 0, rst_b = 0, cat = 0, snoop = 0, ext = 0, lp = 0, pin_n;
  logic clk_en, act, hot_n, hot_oe, trip_n, shut, ack, irq = 0, svc, hirq, tirq;
  logic [7:0] temp = 8'h00, tjm = 8'h64, n;
  ctrl_t ctrl = '0;
  sensor_rd_t sensor;
  int errors = 0, total_checks = 0;
  always #5 clk = ~clk;
  hot_platform hot_platform_i (.drive_i(ext), .dev_n_i(hot_n), .dev_oe_i(hot_oe), .pin_n_o(pin_n));
  thermal_throttle_control #(.SLICE_LEN(2), .HYST_LEN(4)) thermal_throttle_control_i (
    .sys_clk_i(clk), .rst_b_i(rst_b), .ctrl_i(ctrl), .sense_i({temp, tjm, 8'h00, pin_n, lp}),
    .catastrophic_i(cat), .irq_req_i(irq), .snoop_req_i(snoop), .core_clk_en_o(clk_en),
    .throttle_active_o(act), .hot_indicator_n_o(hot_n), .hot_indicator_oe_o(hot_oe),
    .catastrophic_trip_n_o(trip_n), .shutdown_o(shut), .irq_service_o(svc), .snoop_ack_o(ack),
    .hot_irq_o(hirq), .thr_irq_o(tirq), .sensor_o(sensor));
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Clock-on cycles over one 16-cycle period
  task automatic on_count();
    n = 8'h00;
    repeat (16)
    begin
      step(1);
      n += {7'h00, clk_en === 1'b1};
    end
  endtask
  // Bounded wait for the throttle level
  task automatic wait_act(input logic v);
    for (int i = 0; i < 64 && act !== v; i++)
      step(1);
    chk({7'h00, act}, {7'h00, v});
    if (act !== v)
      summarize();
  endtask
  task automatic t_demand();
    ctrl.od_en = 1'b1;
    for (int d = 0; d < 8; d++)
    begin
      ctrl.od_duty = 3'(d);
      step(40);
      on_count();
      chk(n, 8'(((d == 0) ? 1 : d) * 2));
    end
    ctrl.od_en = 1'b0;
    wait_act(1'b0);
  endtask
  task automatic t_auto();
    ctrl = '{auto_en: 1'b1, od_en: 1'b1, default: '0};
    temp = tjm;
    wait_act(1'b1);
    step(32);
    on_count();
    chk(n, 8'h08);
    chk({6'h00, hot_oe, pin_n}, 8'h02);
    chk(sensor.margin, 8'h00);
    temp = 8'h50;
    ctrl.od_en = 1'b0;
    wait_act(1'b0);
    chk({sensor.margin}, 8'h14);
  endtask
  task automatic t_ext();
    ext = 1'b1;
    wait_act(1'b1);
    ext = 1'b0;
    wait_act(1'b0);
    lp = 1'b1;
    step(2);
    chk({7'h00, sensor.valid}, 8'h00);
    lp = 1'b0;
  endtask
  // Hot and threshold pulses on both edges, latched interrupt served
  task automatic t_irq();
    int i;
    ctrl.thr1 = 8'h60;
    step(2);
    ctrl.hot_irq_en = 1'b1;
    ctrl.thr1_irq_en = 1'b1;
    step(2);
    temp = tjm;
    step(1);
    chk({6'h00, hirq, tirq}, 8'h03);
    irq = 1'b1;
    step(1);
    irq = 1'b0;
    for (i = 0; i < 32 && svc !== 1'b1; i++)
      step(1);
    chk({7'h00, svc}, 8'h01);
    temp = 8'h50;
    step(1);
    chk({6'h00, hirq, tirq}, 8'h03);
  endtask
  task automatic t_trip();
    snoop = 1'b1;
    step(1);
    snoop = 1'b0;
    chk({7'h00, ack}, 8'h01);
    cat = 1'b1;
    step(2);
    cat = 1'b0;
    step(3);
    chk({6'h00, trip_n, shut}, 8'h01);
  endtask
  initial
  begin
    step(6);
    chk({5'h00, clk_en, trip_n, hot_n}, 8'h07);
    rst_b = 1'b1;
    t_demand();
    t_auto();
    t_ext();
    t_irq();
    t_trip();
    summarize();
  end
endmodule
